// File: include/pot_defines.svh
`ifndef POT_DEFINES_SVH
`define POT_DEFINES_SVH
// --------------------------------------------------
// clock and timing
// --------------------------------------------------
`define SYS_CLK_HZ 50000000
`define SYS_CLK_NS 20
`define NV_PROG_TIME_MS 5
`define POWERUP_DELAY_MS 1
`define SCL_HALF_NS 1300
`define NV_PROG_CYCLES (`NV_PROG_TIME_MS * (`SYS_CLK_HZ / 1000))
`define POWERUP_CYCLES (`POWERUP_DELAY_MS * (`SYS_CLK_HZ / 1000))
`define SCL_HALF_CYCLES ((`SCL_HALF_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
// --------------------------------------------------
// identity, reset values, field positions
// --------------------------------------------------
`define TYPE_ID_DFLT 4'hA
`define SETTING_RESET 6'h00
`define WIPER_MAX 6'h3F
`define INSTR_OP_LSB 4
`define INSTR_POT_LSB 2
`define INSTR_SEL_LSB 0
// --------------------------------------------------
// host register map and fields
// --------------------------------------------------
`define REG_CTRL 4'h0
`define REG_TXD 4'h4
`define REG_STAT 4'h8
`define REG_RXD 4'hC
`define CTRL_RD_BIT 2
`define CTRL_GO_BIT 3
`define STAT_BUSY_BIT 0
`define STAT_NACK_BIT 1
`define STAT_READY_BIT 2
`endif

// File: include/pot_pkg.sv
`default_nettype none
// --------------------------------------------------
// shared types
// --------------------------------------------------
package pot_pkg;
  // instruction opcodes
  typedef enum logic [3:0] {
    OP_GXFR_TO_WIPER = 4'h1,
    OP_INCDEC = 4'h2,
    OP_GXFR_TO_STORED = 4'h8,
    OP_RD_WIPER = 4'h9,
    OP_WR_WIPER = 4'hA,
    OP_RD_STORED = 4'hB,
    OP_WR_STORED = 4'hC,
    OP_XFR_TO_WIPER = 4'hD,
    OP_XFR_TO_STORED = 4'hE
  } opcode_t;
  // slave protocol states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_INSTR = 3'b010,
    ST_DATA = 3'b011,
    ST_READ = 3'b100,
    ST_INCDEC = 3'b101
  } dev_state_t;
  // master sequencer states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b011,
    H_STOPA = 3'b100,
    H_STOPB = 3'b101
  } host_state_t;
endpackage
`default_nettype wire

// File: include/pot_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------
// two-wire bus, wired-and of all pull-downs
// --------------------------------------------------
interface pot_bus_if;
  logic host_scl_o; // host clock data, always low
  logic host_scl_oe_n; // host pulls clock low when low
  logic host_sda_o; // host data, always low
  logic host_sda_oe_n; // host pulls data low when low
  logic dev_sda_o; // device data, always low
  logic dev_sda_oe_n; // device pulls data low when low
  logic scl; // resolved clock line
  logic sda; // resolved data line
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport device (input scl, sda, output dev_sda_o, dev_sda_oe_n);
  modport host (input scl, sda, output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n);
endinterface
`default_nettype wire

// File: hdl/line_sync.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------
// bus line synchroniser and condition detector
// --------------------------------------------------
module line_sync (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic scl_pin, // raw clock line
  input wire logic sda_pin, // raw data line
  output logic sda_s, // synchronised data level
  output logic scl_rise, // clock rose
  output logic scl_fall, // clock fell
  output logic start_det, // data fell while clock high
  output logic stop_det // data rose while clock high
);
  logic scl_m_r, scl_s_r, scl_d_r; // clock: meta, stable, delayed
  logic sda_m_r, sda_s_r, sda_d_r; // data: meta, stable, delayed
  // two stages then one for edges; idle bus is high
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
    end
    else
    begin
      {scl_m_r, scl_s_r, scl_d_r} <= {scl_pin, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {sda_pin, sda_m_r, sda_s_r};
    end
  end
  assign sda_s = sda_s_r;
  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
endmodule
`default_nettype wire

// File: hdl/pot_slave.sv
// Function
// - host waits 1 ms after power-up
// - programming cycle lasts at most 5 ms
// - bus ignored, data released while programming
// - start is data fall, clock high
// - stop is data rise, clock high
// - data changes only with clock low
// - master starts transfers and makes clock
// - address byte matches type and straps
// - acknowledge matching address on ninth clock
// - acknowledge every written byte
// - read: eight bits, sample master acknowledge
// - write is address, instruction, data, stop
// - stored write programs after stop
// - polling gets acknowledge once programming ends
// - instruction: opcode, pot, setting fields
// - setting select maps zero to three
// - wipers load stored setting zero at power-up
// - increment/decrement steps wiper per clock
// - wiper to stored copy is nonvolatile write
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pot_defines.svh"
module pot_slave
  import pot_pkg::*;
#(
  parameter logic [3:0] TYPE_ID = `TYPE_ID_DFLT, // arbitrary value
  parameter int NV_PROG_CYCLES = `NV_PROG_CYCLES // programming cycle length
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset, power-up
  pot_bus_if.device bus, // two-wire bus
  input wire logic [3:0] strap_address_pins, // strapped address
  output logic [23:0] wiper_settings, // four wiper settings
  output logic nv_busy // programming in progress
);
  localparam int BW = $clog2(NV_PROG_CYCLES + 1);
  // --------------------------------------------------
  // line conditioning
  // --------------------------------------------------
  logic sda_s, scl_rise, scl_fall, start_det, stop_det; // bus events
  logic [3:0] strap_m_r, strap_s_r; // strap synchroniser
  line_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_pin(bus.scl),
    .sda_pin(bus.sda),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );
  // straps are pins, two stages before use
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      strap_m_r <= 4'h0;
      strap_s_r <= 4'h0;
    end
    else
    begin
      strap_m_r <= strap_address_pins;
      strap_s_r <= strap_m_r;
    end
  end
  // --------------------------------------------------
  // protocol state
  // --------------------------------------------------
  dev_state_t st_r; // protocol state
  logic [3:0] cnt_r; // bit count, 9 = ack slot
  logic [7:0] rx_r; // received byte
  logic [7:0] tx_r; // byte being read out
  logic ack_r; // acknowledge this slot
  opcode_t op_r; // latched opcode
  logic [1:0] pot_r, sel_r; // latched pointers
  logic nv_pend_r, nv_glob_r, nv_src_r; // pending store: all pots, from wiper
  logic [5:0] nv_val_r; // pending store value
  logic busy_r; // programming cycle running
  logic [BW-1:0] bcnt_r; // programming cycle counter
  logic init_r; // first cycle after reset
  logic sda_low_r; // data pull-down
  logic [5:0] wiper_w [4]; // wiper setting registers
  logic [5:0] stored_w [16]; // stored setting registers
  // decoding of the received instruction byte
  opcode_t rx_op; // opcode field
  logic [1:0] rx_pot, rx_sel; // pointer fields
  assign rx_op = opcode_t'(rx_r[`INSTR_OP_LSB +: 4]);
  assign rx_pot = rx_r[`INSTR_POT_LSB +: 2];
  assign rx_sel = rx_r[`INSTR_SEL_LSB +: 2];
  // event qualifiers
  logic rx_state, bit_in, byte_end, ack_end, addr_hit, instr_done, data_done;
  assign rx_state = (st_r == ST_ADDR) | (st_r == ST_INSTR) | (st_r == ST_DATA);
  assign bit_in = rx_state & scl_rise & (cnt_r < 4'h8);
  assign byte_end = rx_state & scl_fall & (cnt_r == 4'h8);
  assign ack_end = scl_fall & (cnt_r == 4'h9);
  assign addr_hit = rx_r == {TYPE_ID, strap_s_r};
  assign instr_done = byte_end & (st_r == ST_INSTR);
  assign data_done = byte_end & (st_r == ST_DATA);
  // state that follows an instruction byte
  function automatic dev_state_t after_instr(input opcode_t op);
    unique case (op)
      OP_RD_WIPER, OP_RD_STORED: after_instr = ST_READ;
      OP_WR_WIPER, OP_WR_STORED: after_instr = ST_DATA;
      OP_INCDEC: after_instr = ST_INCDEC;
      default: after_instr = ST_IDLE; // transfers and unknown codes
    endcase
  endfunction
  // value that a read instruction returns
  logic [5:0] rd_val;
  assign rd_val = (rx_op == OP_RD_WIPER) ? wiper_w[rx_pot] : stored_w[{rx_pot, rx_sel}];
  // --------------------------------------------------
  // protocol engine
  // --------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      ack_r <= 1'b0;
      op_r <= OP_RD_WIPER;
      pot_r <= 2'h0;
      sel_r <= 2'h0;
      nv_pend_r <= 1'b0;
      nv_glob_r <= 1'b0;
      nv_src_r <= 1'b0;
      nv_val_r <= 6'h00;
      busy_r <= 1'b0;
      bcnt_r <= '0;
      init_r <= 1'b1;
    end
    else
    begin
      init_r <= 1'b0;
      if (busy_r)
      begin
        // interface disabled, count down the cycle
        st_r <= ST_IDLE;
        ack_r <= 1'b0;
        cnt_r <= 4'h0;
        bcnt_r <= bcnt_r - 1'b1;
        if (bcnt_r == '0)
          busy_r <= 1'b0;
      end
      else if (stop_det)
      begin
        // end of operation, launch pending programming
        st_r <= ST_IDLE;
        ack_r <= 1'b0;
        cnt_r <= 4'h0;
        if (nv_pend_r)
        begin
          busy_r <= 1'b1;
          bcnt_r <= BW'(NV_PROG_CYCLES - 1);
          nv_pend_r <= 1'b0;
        end
      end
      else if (start_det)
      begin
        // start or repeated start opens a new address byte
        st_r <= ST_ADDR;
        ack_r <= 1'b0;
        cnt_r <= 4'h0;
        nv_pend_r <= 1'b0;
      end
      else
      begin
        if (bit_in)
        begin
          rx_r <= {rx_r[6:0], sda_s};
          cnt_r <= cnt_r + 4'h1;
        end
        if (byte_end)
        begin
          cnt_r <= 4'h9;
          unique case (st_r)
            ST_ADDR:
            begin
              ack_r <= addr_hit;
              st_r <= addr_hit ? ST_INSTR : ST_IDLE;
            end
            ST_INSTR:
            begin
              ack_r <= 1'b1;
              op_r <= rx_op;
              pot_r <= rx_pot;
              sel_r <= rx_sel;
              tx_r <= {2'b00, rd_val};
              st_r <= after_instr(rx_op);
              if (rx_op == OP_XFR_TO_STORED || rx_op == OP_GXFR_TO_STORED)
              begin
                nv_pend_r <= 1'b1;
                nv_src_r <= 1'b1;
                nv_glob_r <= rx_op == OP_GXFR_TO_STORED;
              end
            end
            default:
            begin
              // data byte; a stored write waits for stop
              ack_r <= 1'b1;
              st_r <= ST_IDLE;
              if (op_r == OP_WR_STORED)
              begin
                nv_pend_r <= 1'b1;
                nv_src_r <= 1'b0;
                nv_glob_r <= 1'b0;
                nv_val_r <= rx_r[5:0];
              end
            end
          endcase
        end
        else if (ack_end)
        begin
          ack_r <= 1'b0;
          cnt_r <= 4'h0;
        end
        else if (st_r == ST_READ && scl_fall)
          cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
        else if (st_r == ST_READ && scl_rise && cnt_r == 4'h8 && sda_s)
          st_r <= ST_IDLE; // no master acknowledge
      end
    end
  end
  // --------------------------------------------------
  // data pin: open-drain low only
  // --------------------------------------------------
  logic want_low;
  assign want_low = ~busy_r & (((cnt_r == 4'h9) & ack_r)
    | ((st_r == ST_READ) & (cnt_r < 4'h8) & ~tx_r[~cnt_r[2:0]]));
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      sda_low_r <= 1'b0;
    else
      sda_low_r <= want_low;
  end
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = ~sda_low_r;
  // --------------------------------------------------
  // stored setting registers
  // --------------------------------------------------
  logic commit; // stop that launches programming
  assign commit = ~busy_r & stop_det & nv_pend_r;
  for (genvar e = 0; e < 16; e++)
  begin : g_stored
    logic [5:0] s_r; // one stored setting
    always_ff @(posedge sys_clk)
    begin
      if (rst)
        s_r <= `SETTING_RESET;
      else if (commit && sel_r == 2'(e % 4) && (nv_glob_r || pot_r == 2'(e / 4)))
        s_r <= nv_src_r ? wiper_w[e / 4] : nv_val_r;
    end
    assign stored_w[e] = s_r;
  end
  // --------------------------------------------------
  // wiper setting registers
  // --------------------------------------------------
  logic step; // increment/decrement pulse
  assign step = ~busy_r & (st_r == ST_INCDEC) & scl_rise & (cnt_r == 4'h0);
  for (genvar p = 0; p < 4; p++)
  begin : g_wiper
    logic [5:0] w_r; // one wiper setting
    always_ff @(posedge sys_clk)
    begin
      if (rst)
        w_r <= `SETTING_RESET;
      else if (init_r)
        w_r <= stored_w[p * 4];
      else if (data_done && op_r == OP_WR_WIPER && pot_r == 2'(p))
        w_r <= rx_r[5:0];
      else if (instr_done && (rx_op == OP_GXFR_TO_WIPER || (rx_op == OP_XFR_TO_WIPER && rx_pot == 2'(p))))
        w_r <= stored_w[{2'(p), rx_sel}];
      else if (step && pot_r == 2'(p))
      begin
        if (sda_s && w_r != `WIPER_MAX)
          w_r <= w_r + 6'h01; // toward high end
        else if (!sda_s && w_r != 6'h00)
          w_r <= w_r - 6'h01; // toward low end
      end
    end
    assign wiper_w[p] = w_r;
    assign wiper_settings[p * 6 +: 6] = w_r;
  end
  assign nv_busy = busy_r;
endmodule
`default_nettype wire

// File: hdl/pot_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "pot_defines.svh"
module pot_master
  import pot_pkg::*;
#(
  parameter logic [3:0] TYPE_ID = `TYPE_ID_DFLT, // arbitrary value
  parameter int POWERUP_CYCLES = `POWERUP_CYCLES, // power-up wait
  parameter int HALF = `SCL_HALF_CYCLES // clock half period
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset
  pot_bus_if.host bus, // two-wire bus
  input wire logic [3:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata // read data, cycle after strobe
);
  localparam int PW = $clog2(POWERUP_CYCLES + 1);
  // --------------------------------------------------
  // registers
  // --------------------------------------------------
  host_state_t st_r; // sequencer state
  logic [1:0] len_r; // bytes after the address
  logic rdl_r; // last byte is read
  logic [19:0] txd_r; // strap address, instruction, data
  logic nack_r, ready_r; // no acknowledge, power-up over
  logic [7:0] rxd_r, sh_r; // read byte, shifter
  logic [PW-1:0] pu_r; // power-up counter
  logic [$clog2(HALF + 1)-1:0] div_r; // half-period divider
  logic [3:0] bit_r; // bit count, 8 = ack slot
  logic [1:0] byte_r; // byte index
  logic scl_low_r, sda_low_r; // pull-downs
  logic [31:0] rdata_r; // read data
  logic sda_s; // synchronised data
  line_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_pin(bus.scl),
    .sda_pin(bus.sda),
    .sda_s(sda_s),
    .scl_rise(),
    .scl_fall(),
    .start_det(),
    .stop_det()
  );
  // byte of the frame by index
  function automatic logic [7:0] frame_byte(input logic [1:0] i, input logic [19:0] t);
    frame_byte = (i == 2'h0) ? {TYPE_ID, t[19:16]} : (i == 2'h1) ? t[15:8] : t[7:0];
  endfunction
  logic go, tick, mid, rd_byte, wr_ctrl;
  assign wr_ctrl = reg_wr & (reg_addr == `REG_CTRL);
  assign go = wr_ctrl & reg_wdata[`CTRL_GO_BIT] & ready_r & (st_r == H_IDLE);
  assign tick = div_r == ($bits(div_r))'(HALF - 1);
  assign mid = div_r == ($bits(div_r))'(HALF / 2);
  assign rd_byte = rdl_r & (byte_r == len_r) & (byte_r != 2'h0);
  // --------------------------------------------------
  // software port
  // --------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      len_r <= 2'h0;
      rdl_r <= 1'b0;
      txd_r <= 20'h00000;
      rdata_r <= 32'h00000000;
      pu_r <= '0;
      ready_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && st_r == H_IDLE)
      begin
        len_r <= reg_wdata[1:0];
        rdl_r <= reg_wdata[`CTRL_RD_BIT];
      end
      if (reg_wr && reg_addr == `REG_TXD && st_r == H_IDLE)
        txd_r <= reg_wdata[19:0];
      // power-up wait before any operation
      if (!ready_r)
        pu_r <= pu_r + 1'b1;
      if (pu_r == PW'(POWERUP_CYCLES - 1))
        ready_r <= 1'b1;
      rdata_r <= 32'h00000000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          `REG_CTRL: rdata_r <= {29'h0, rdl_r, len_r};
          `REG_TXD: rdata_r <= {12'h000, txd_r};
          `REG_STAT: rdata_r <= {29'h0, ready_r, nack_r, st_r != H_IDLE};
          `REG_RXD: rdata_r <= {24'h000000, rxd_r};
          default: rdata_r <= 32'h00000000;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_r;
  // --------------------------------------------------
  // bus sequencer
  // --------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= H_IDLE;
      div_r <= '0;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      sh_r <= 8'h00;
      rxd_r <= 8'h00;
      nack_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end
    else
    begin
      div_r <= (st_r == H_IDLE || tick) ? '0 : div_r + 1'b1;
      unique case (st_r)
        H_IDLE:
          if (go)
          begin
            sda_low_r <= 1'b1; // start
            nack_r <= 1'b0;
            byte_r <= 2'h0;
            st_r <= H_START;
          end
        H_START:
          if (tick)
          begin
            scl_low_r <= 1'b1;
            sh_r <= frame_byte(2'h0, txd_r);
            bit_r <= 4'h0;
            st_r <= H_LOW;
          end
        H_LOW:
        begin
          if (mid)
            sda_low_r <= (bit_r < 4'h8) & ~rd_byte & ~sh_r[7];
          if (tick)
          begin
            scl_low_r <= 1'b0;
            st_r <= H_HIGH;
          end
        end
        H_HIGH:
          if (tick)
          begin
            scl_low_r <= 1'b1;
            st_r <= H_LOW;
            if (bit_r < 4'h8)
            begin
              sh_r <= {sh_r[6:0], sda_s};
              bit_r <= bit_r + 4'h1;
            end
            else
            begin
              if (rd_byte)
                rxd_r <= sh_r; // one byte, then no acknowledge
              if (!rd_byte && sda_s)
              begin
                nack_r <= 1'b1;
                st_r <= H_STOPA;
              end
              else if (byte_r == len_r)
                st_r <= H_STOPA;
              else
              begin
                byte_r <= byte_r + 2'h1;
                sh_r <= frame_byte(byte_r + 2'h1, txd_r);
                bit_r <= 4'h0;
              end
            end
          end
        H_STOPA:
        begin
          if (mid)
            sda_low_r <= 1'b1;
          if (tick)
          begin
            scl_low_r <= 1'b0;
            st_r <= H_STOPB;
          end
        end
        default:
          if (tick)
          begin
            sda_low_r <= 1'b0; // stop
            st_r <= H_IDLE;
          end
      endcase
    end
  end
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe_n = ~scl_low_r;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe_n = ~sda_low_r;
endmodule
`default_nettype wire

// File: verif/pot_bus_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// bus checker
// ------------------------------
module pot_bus_sva #(
  parameter int NV = 200 // busy length
) (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire logic scl, // clock line
  input wire logic sda, // data line
  input wire logic dev_sda_o, // device data
  input wire logic dev_sda_oe_n, // device pull-down
  input wire logic nv_busy // programming
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic scl_r, sda_r, frame_r; // last levels, frame open
  logic [15:0] busy_n_r, since_r; // busy length, cycles since stop
  wire stop_w = scl && scl_r && sda && !sda_r; // stop on the pins
  wire start_w = scl && scl_r && !sda && sda_r; // start on the pins
  // track frame and counters
  always_ff @(posedge sys_clk)
  begin
    scl_r <= rst | scl;
    sda_r <= rst | sda;
    frame_r <= !rst && (start_w || (frame_r && !stop_w));
    busy_n_r <= (nv_busy && !rst) ? busy_n_r + 16'h1 : 16'h0;
    since_r <= (stop_w || rst) ? 16'h0 : since_r + {15'h0, since_r != 16'hFFFF};
  end
  sequence pull_s;
    $fell(dev_sda_oe_n);
  endsequence
  a_open_drain: assert property (!dev_sda_oe_n |-> !dev_sda_o) else $error("data driven high");
  a_busy_quiet: assert property (nv_busy |-> dev_sda_oe_n) else $error("drive while busy");
  a_busy_bound: assert property (busy_n_r <= NV) else $error("busy too long");
  a_busy_stop: assert property ($rose(nv_busy) |-> since_r < 16) else $error("busy without stop");
  a_pull_low: assert property (pull_s |-> !scl) else $error("pull with clock high");
  a_free_low: assert property ($rose(dev_sda_oe_n) |-> !scl) else $error("release with clock high");
  a_pull_stands: assert property (pull_s |-> !dev_sda_oe_n [*8]) else $error("pull too short");
  a_idle_quiet: assert property (!frame_r |-> dev_sda_oe_n) else $error("drive outside frame");
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// bench top
// ------------------------------
module tb;
  import pot_pkg::*;
  localparam int NV = 2000; // shortened busy length
  logic sys_clk, rst, reg_wr, reg_rd, nv_busy; // clock, reset, strobes
  logic [3:0] strap, reg_addr; // straps, address
  logic [31:0] reg_wdata, reg_rdata, rv; // data, last read
  logic [23:0] wiper_settings; // wipers
  int n_mismatch, num_checks; // counters
  pot_bus_if bus ();
  pot_slave #(.NV_PROG_CYCLES(NV)) pot_slave_i (.sys_clk(sys_clk), .rst(rst), .bus(bus),
    .strap_address_pins(strap), .wiper_settings(wiper_settings), .nv_busy(nv_busy));
  pot_master #(.POWERUP_CYCLES(100), .HALF(16)) pot_master_i (.sys_clk(sys_clk), .rst(rst), .bus(bus),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  pot_bus_sva #(.NV(NV)) pot_bus_sva_i (.sys_clk(sys_clk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe_n(bus.dev_sda_oe_n), .nv_busy(nv_busy));
  always #10 sys_clk = ~sys_clk;
  // ------------------------------
  // tasks
  // ------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      n_mismatch++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // one bus transfer, ends with status in rv
  task xfer(input logic [1:0] len, input logic rdb, input logic [3:0] sa, input logic [7:0] ins, input logic [7:0] d);
    wr(4'h4, {12'h000, sa, ins, d});
    wr(4'h0, {28'h0, 1'b1, rdb, len});
    rv = 32'h1;
    for (int i = 0; i < 3000 && rv[0] !== 1'b0; i++) rd(4'h8);
    chk(rv[0], 0, "transfer done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------------------------
  // tests
  // ------------------------------
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    strap = 4'h3;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h8);
    chk(rv[2], 0, "ready early");
    chk(wiper_settings, 0, "wipers after reset");
    for (int i = 0; i < 200 && rv[2] !== 1'b1; i++) rd(4'h8);
    chk(rv[2], 1, "ready late");
    xfer(2, 0, 4'h3, {OP_WR_WIPER, 4'h8}, 8'h2A);
    chk(rv[1], 0, "write nack");
    chk(wiper_settings[17:12], 6'h2A, "wiper two");
    xfer(2, 1, 4'h3, {OP_RD_WIPER, 4'h8}, 8'h00);
    rd(4'hC);
    chk(rv[7:0], 8'h2A, "read wiper");
    $display("test wiper write and read done");
    xfer(2, 0, 4'h5, {OP_WR_WIPER, 4'h8}, 8'h11);
    chk(rv[1], 1, "mismatch nack");
    chk(wiper_settings[17:12], 6'h2A, "wiper kept");
    $display("test address mismatch done");
    // nine clock pulses with data high, then the stop's clock rise with data low
    xfer(2, 0, 4'h3, {OP_INCDEC, 4'h8}, 8'hFF);
    chk(wiper_settings[17:12], 6'h32, "wiper stepped");
    $display("test increment done");
    xfer(2, 0, 4'h3, {OP_WR_STORED, 4'h7}, 8'h15);
    chk(rv[1], 0, "stored nack");
    repeat (4) @(posedge sys_clk);
    chk(nv_busy, 1, "busy after stop");
    xfer(0, 0, 4'h3, 8'h00, 8'h00);
    chk(rv[1], 1, "poll while busy");
    repeat (NV) @(posedge sys_clk);
    xfer(0, 0, 4'h3, 8'h00, 8'h00);
    chk(rv[1], 0, "poll after busy");
    chk(nv_busy, 0, "busy over");
    xfer(2, 1, 4'h3, {OP_RD_STORED, 4'h7}, 8'h00);
    rd(4'hC);
    chk(rv[7:0], 8'h15, "read stored");
    xfer(1, 0, 4'h3, {OP_XFR_TO_WIPER, 4'h7}, 8'h00);
    chk(wiper_settings[11:6], 6'h15, "stored to wiper");
    xfer(1, 0, 4'h3, {OP_XFR_TO_STORED, 4'h9}, 8'h00);
    repeat (NV + 8) @(posedge sys_clk);
    xfer(2, 1, 4'h3, {OP_RD_STORED, 4'h9}, 8'h00);
    rd(4'hC);
    chk(rv[7:0], 8'h32, "wiper to stored");
    $display("test stored write and polling done");
    @(posedge sys_clk);
    strap <= 4'hC;
    xfer(2, 1, 4'hC, {OP_RD_WIPER, 4'h4}, 8'h00);
    chk(rv[1], 0, "new strap nack");
    rd(4'hC);
    chk(rv[7:0], 8'h15, "read wiper one");
    rd(4'h2);
    chk(rv, 0, "unmapped read");
    $display("test strap change done");
    give_verdict;
  end
  initial
  begin
    #1000000;
    n_mismatch++;
    give_verdict;
  end
endmodule
`default_nettype wire
